// file: verilog/pmc_pkg.sv
// constants, field layouts and state types of the power-managed clock controller
// assumes a 200 MHz controller clock; all counts are in cycles of that clock
package pmc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OSC_CTRL_ADDR  = 8'h00;
  localparam logic [7:0]  TMR_CTRL_ADDR  = 8'h04;
  localparam logic [7:0]  MODE_STAT_ADDR = 8'h08;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned IDLE_EN_BIT    = 7;
  localparam int unsigned PRI_FLAG_BIT   = 3;
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned SEC_FLAG_BIT   = 6;
  localparam int unsigned SEC_EN_BIT     = 3;
  localparam int unsigned STAT_SRC_LSB   = 4;

  // ---------------------------------------------------------------
  // clock select encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_PRI        = 2'h2;
  localparam logic [1:0] SEL_SEC        = 2'h1;
  localparam logic [1:0] SEL_INT        = 2'h3;
  localparam logic [1:0] SEL_RESET      = SEL_PRI;
  localparam logic       IDLE_EN_RESET  = 1'b0;
  localparam logic       SEC_EN_RESET   = 1'b0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned CPU_READY_NS   = 100;
  localparam int unsigned CPU_READY_CYC  = (CPU_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SWITCH_OLD_CYC = 2;
  localparam int unsigned SWITCH_NEW_CYC = 4;
  localparam int unsigned SWITCH_CYC     = SWITCH_OLD_CYC + SWITCH_NEW_CYC;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRC_NONE, SRC_PRI, SRC_SEC, SRC_INT} pmc_src_type;

  typedef enum logic [2:0] {
    ST_BOOT, ST_RUN, ST_SWITCH, ST_IDLE, ST_SLEEP, ST_WAKE, ST_READY
  } pmc_state_type;

endpackage

// file: verilog/pmc_cnt_if.sv
// start/len request and busy/done answer between controller and delay counter
// assumes both ends share one clock
`timescale 1ns/1ps
interface pmc_cnt_if;
  import pmc_pkg::*;
  logic             start;
  logic [CNT_W-1:0] len;
  logic             busy;
  logic             done;
  modport ctrl (output start, output len, input busy, input done);
  modport cnt  (input start, input len, output busy, output done);
endinterface

// file: verilog/pmc_delay_cnt.sv
// one-shot delay counter: done rises len cycles after the start edge
// assumes len is at least one and start is a one-cycle request
`timescale 1ns/1ps
module pmc_delay_cnt
  import pmc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  // request side
  pmc_cnt_if.cnt    cnt
);

  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] count;
  } pmc_cnt_state_type;

  pmc_cnt_state_type cs_q;
  pmc_cnt_state_type cs_d;

  always_comb begin
    cs_d = cs_q;
    if (ce_i) begin
      if (cnt.start) begin
        cs_d.busy  = 1'b1;
        cs_d.count = cnt.len - CNT_W'(1);
      end else if (cs_q.busy) begin
        if (cs_q.count == '0) begin
          cs_d.busy = 1'b0;
        end else begin
          cs_d.count = cs_q.count - CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_q <= '0;
    end else begin
      cs_q <= cs_d;
    end
  end

  assign cnt.busy = cs_q.busy;
  assign cnt.done = cs_q.busy && (cs_q.count == '0);

endmodule // pmc_delay_cnt

// file: verilog/pmc_top.sv
// power-managed clock mode controller: run, idle and sleep sequencing with apb registers
// assumes oscillator ready levels and cpu events are synchronous to ref_clk_i
//
// How it works
// [R01] after reset run on primary, flag set; with two_speed_en_i the code starts on internal, flag clear
// [R02] select 01 moves clocks to secondary
// [R03] secondary disabled blocks secondary run entry
// [R04] secondary enabled not running holds clocks
// [R05] secondary to primary waits primary ready
// [R06] select 11 moves clocks to internal
// [R07] internal to primary waits primary ready
// [R08] internal stays on with watchdog or monitor
// [R09] switches and wakes keep select bits
// [R10] sleep stops source, clears all flags
// [R11] watchdog and secondary enable keep oscillators
// [R12] sleep wake waits source or internal
// [R13] idle stops cpu, keeps peripherals, flags
// [R14] idle exits on wake, then ready delay
// [R15] watchdog timeout wakes instead of resetting
// [R16] primary idle keeps primary and flag
// [R17] primary idle wake resumes on primary
// [R18] secondary idle shuts primary, sets secondary
// [R19] secondary idle refused if disabled
// [R20] internal idle shuts primary, clears flag
// [R21] idle wake keeps peripheral clock source
// [R22] switch takes old plus new cycles
// [R23] idle enable bit7, select bits 1:0
// [R24] no flag means internal oscillator
// [R25] cpu ready delay is a parameter
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
#(
  parameter int unsigned READY_CYC  = CPU_READY_CYC,
  parameter int unsigned SWITCH_LEN = SWITCH_CYC
) (
  // clock, reset, enable
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // cpu events and configuration
  input  wire logic              sleep_req_i,
  input  wire logic              wake_irq_i,
  input  wire logic              wdt_timeout_i,
  input  wire logic              wdt_en_i,
  input  wire logic              fscm_en_i,
  input  wire logic              two_speed_en_i,
  // oscillator status
  input  wire logic              primary_ready_i,
  input  wire logic              secondary_running_i,
  // clock control outputs
  output logic                   cpu_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic [1:0]             clk_src_o,
  output logic                   primary_osc_en_o,
  output logic                   secondary_osc_en_o,
  output logic                   internal_osc_en_o,
  output logic                   primary_clock_active_flag_o,
  output logic                   secondary_clock_active_flag_o,
  output logic                   wdt_reset_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pmc_state_type st;
    pmc_src_type   src;
    pmc_src_type   sw_tgt;
    logic          idle_pend;
    logic [1:0]    clock_select_field;
    logic          idle_enable_bit;
    logic          secondary_osc_enable_bit;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          cpu_clk_en;
    logic          periph_clk_en;
    logic [1:0]    clk_src;
    logic          pri_osc_en;
    logic          sec_osc_en;
    logic          int_osc_en;
    logic          pri_flag;
    logic          sec_flag;
    logic          wdt_rst;
  } pmc_top_state_type;

  pmc_top_state_type cs_q;
  pmc_top_state_type cs_d;
  pmc_src_type       tgt;
  logic              hit;
  logic              hold;
  logic [31:0]       rd;

  pmc_cnt_if cnt ();
  pmc_delay_cnt u_delay (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .cnt       (cnt.cnt)
  );

  function automatic pmc_src_type sel_to_src(input logic [1:0] sel);
    case (sel)
      SEL_PRI: sel_to_src = SRC_PRI;
      SEL_SEC: sel_to_src = SRC_SEC;
      default: sel_to_src = SRC_INT; // 00 and 11 both pick the internal oscillator
    endcase
  endfunction

  function automatic logic src_ready(input pmc_src_type s, input logic sec_en,
                                     input logic pri_rdy, input logic secondary_run_mode);
    case (s)
      SRC_PRI: src_ready = pri_rdy;
      SRC_SEC: src_ready = sec_en && secondary_run_mode;
      SRC_INT: src_ready = 1'b1;
      default: src_ready = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    cs_d      = cs_q;
    cnt.start = 1'b0;
    cnt.len   = '0;
    tgt       = sel_to_src(cs_q.clock_select_field);
    hit       = (paddr_i == OSC_CTRL_ADDR) || (paddr_i == TMR_CTRL_ADDR) ||
                (paddr_i == MODE_STAT_ADDR);
    rd        = '0;
    case (paddr_i)
      OSC_CTRL_ADDR: begin
        rd[IDLE_EN_BIT]         = cs_q.idle_enable_bit;
        rd[PRI_FLAG_BIT]        = cs_q.pri_flag;
        rd[SEL_LSB+1:SEL_LSB]   = cs_q.clock_select_field; // R23
      end
      TMR_CTRL_ADDR: begin
        rd[SEC_FLAG_BIT]        = cs_q.sec_flag;
        rd[SEC_EN_BIT]          = cs_q.secondary_osc_enable_bit;
      end
      MODE_STAT_ADDR: begin
        rd[2:0]                 = cs_q.st;
        rd[STAT_SRC_LSB+1:STAT_SRC_LSB] = cs_q.src;
      end
      default: rd = '0;
    endcase
    // a switch to secondary holds off the cpu and peripheral clocks until the secondary oscillates
    hold = (cs_q.st == ST_SWITCH) && (cs_q.sw_tgt == SRC_SEC) && !secondary_running_i; // R04

    if (ce_i) begin
      // -------------------------------------------------------------
      // apb slave: one wait-free access phase, data prepared in setup
      // -------------------------------------------------------------
      cs_d.pready  = psel_i && !penable_i;
      cs_d.pslverr = psel_i && !penable_i && !hit;
      cs_d.prdata  = (psel_i && !penable_i && !pwrite_i) ? rd : '0;
      // only software moves the select and idle bits
      if (psel_i && penable_i && cs_q.pready && pwrite_i) begin // R09
        if (paddr_i == OSC_CTRL_ADDR) begin
          cs_d.idle_enable_bit    = pwdata_i[IDLE_EN_BIT]; // R23
          cs_d.clock_select_field = pwdata_i[SEL_LSB+1:SEL_LSB]; // R23
        end
        if (paddr_i == TMR_CTRL_ADDR) begin
          cs_d.secondary_osc_enable_bit = pwdata_i[SEC_EN_BIT];
        end
      end
      cs_d.wdt_rst = 1'b0;

      // -------------------------------------------------------------
      // mode sequencer
      // -------------------------------------------------------------
      case (cs_q.st)
        ST_BOOT: begin
          cs_d.st  = ST_RUN;
          cs_d.src = two_speed_en_i ? SRC_INT : SRC_PRI; // R01
        end
        ST_RUN: begin
          if (wdt_timeout_i) begin
            cs_d.wdt_rst = 1'b1; // executing code, so the watchdog resets
          end else if (sleep_req_i) begin
            if (!cs_q.idle_enable_bit) begin
              cs_d.st  = ST_SLEEP;
              cs_d.src = SRC_NONE; // R10
            end else if (tgt == SRC_SEC && !cs_q.secondary_osc_enable_bit) begin
              cs_d.st = ST_RUN; // R19
            end else if (tgt == cs_q.src) begin
              cs_d.st = ST_IDLE; // R13 R16
            end else begin
              cs_d.st        = ST_SWITCH; // R18 R20
              cs_d.sw_tgt    = tgt;
              cs_d.idle_pend = 1'b1;
            end
          end else if (tgt != cs_q.src) begin
            if (tgt == SRC_SEC && !cs_q.secondary_osc_enable_bit) begin
              cs_d.st = ST_RUN; // R03
            end else begin
              cs_d.st        = ST_SWITCH; // R02 R06
              cs_d.sw_tgt    = tgt;
              cs_d.idle_pend = 1'b0;
            end
          end
        end
        ST_SWITCH: begin
          // old source clocks until the switch count ends, held off while a secondary target is not running; an idle request meanwhile is kept
          cs_d.idle_pend = cs_q.idle_pend || (sleep_req_i && cs_q.idle_enable_bit); // R16 R18 R20
          if (sleep_req_i && !cs_q.idle_enable_bit) begin
            cs_d.st  = ST_SLEEP; // R10
            cs_d.src = SRC_NONE;
          end else if (cnt.done) begin
            cs_d.src = cs_q.sw_tgt; // R05 R07
            cs_d.st  = cs_d.idle_pend ? ST_IDLE : ST_RUN;
          end else if (!cnt.busy && src_ready(cs_q.sw_tgt, cs_q.secondary_osc_enable_bit,
                                              primary_ready_i, secondary_running_i)) begin
            cnt.start = 1'b1;
            cnt.len   = CNT_W'(SWITCH_LEN); // R22
          end
        end
        ST_IDLE: begin
          if (wake_irq_i || wdt_timeout_i) begin
            cs_d.st   = ST_READY; // R14 R15 R17 R21
            cnt.start = 1'b1;
            cnt.len   = CNT_W'(READY_CYC); // R25
          end
        end
        ST_SLEEP: begin
          if (wake_irq_i || wdt_timeout_i) begin // R15
            if (tgt == SRC_INT || two_speed_en_i || fscm_en_i) begin
              cs_d.st   = ST_READY; // R12
              cs_d.src  = SRC_INT;
              cnt.start = 1'b1;
              cnt.len   = CNT_W'(READY_CYC);
            end else begin
              cs_d.st     = ST_WAKE;
              cs_d.sw_tgt = tgt;
            end
          end
        end
        ST_WAKE: begin
          // unclocked until the selected source comes up
          if (src_ready(cs_q.sw_tgt, cs_q.secondary_osc_enable_bit,
                        primary_ready_i, secondary_running_i)) begin
            cs_d.st   = ST_READY; // R12
            cs_d.src  = cs_q.sw_tgt;
            cnt.start = 1'b1;
            cnt.len   = CNT_W'(READY_CYC);
          end
        end
        ST_READY: begin
          if (cnt.done) begin
            cs_d.st = ST_RUN; // R14
          end
        end
        default: cs_d.st = ST_BOOT;
      endcase

      // -------------------------------------------------------------
      // registered clock controls from the present state
      // -------------------------------------------------------------
      cs_d.cpu_clk_en    = (cs_q.st == ST_RUN) || ((cs_q.st == ST_SWITCH) && !hold);
      cs_d.periph_clk_en = cs_d.cpu_clk_en || (cs_q.st == ST_IDLE) || (cs_q.st == ST_READY); // R13
      cs_d.clk_src       = cs_q.src; // R24
      cs_d.pri_flag      = (cs_q.src == SRC_PRI); // R01 R17
      cs_d.sec_flag      = (cs_q.src == SRC_SEC); // R18
      cs_d.pri_osc_en    = ((cs_q.src == SRC_PRI) && (cs_q.st != ST_SLEEP)) ||
                           (((cs_q.st == ST_SWITCH) || (cs_q.st == ST_WAKE)) &&
                            (cs_q.sw_tgt == SRC_PRI));
      cs_d.sec_osc_en    = cs_q.secondary_osc_enable_bit; // R11
      cs_d.int_osc_en    = wdt_en_i || fscm_en_i || (cs_q.src == SRC_INT) || // R08 R11
                           (cs_q.sw_tgt == SRC_INT && cs_q.st == ST_SWITCH);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_q                          <= '0;
      cs_q.st                       <= ST_BOOT;
      cs_q.src                      <= SRC_NONE;
      cs_q.sw_tgt                   <= SRC_NONE;
      cs_q.clock_select_field       <= SEL_RESET;
      cs_q.idle_enable_bit          <= IDLE_EN_RESET;
      cs_q.secondary_osc_enable_bit <= SEC_EN_RESET;
    end else begin
      cs_q <= cs_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o                      = cs_q.prdata;
  assign pready_o                      = cs_q.pready;
  assign pslverr_o                     = cs_q.pslverr;
  assign cpu_clk_en_o                  = cs_q.cpu_clk_en;
  assign periph_clk_en_o               = cs_q.periph_clk_en;
  assign clk_src_o                     = cs_q.clk_src;
  assign primary_osc_en_o              = cs_q.pri_osc_en;
  assign secondary_osc_en_o            = cs_q.sec_osc_en;
  assign internal_osc_en_o             = cs_q.int_osc_en;
  assign primary_clock_active_flag_o   = cs_q.pri_flag;
  assign secondary_clock_active_flag_o = cs_q.sec_flag;
  assign wdt_reset_o                   = cs_q.wdt_rst;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] rdy_len_q;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdy_len_q <= '0;
    end else if (ce_i) begin
      rdy_len_q <= (cs_q.st == ST_READY) ? rdy_len_q + CNT_W'(1) : '0;
    end
  end

  default clocking dclk @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_sleep_flags_clear: assert property ( // R10
    ce_i && cs_q.st == ST_RUN && sleep_req_i && !wdt_timeout_i && !cs_q.idle_enable_bit ##1 ce_i
    |=> !primary_clock_active_flag_o && !secondary_clock_active_flag_o && !periph_clk_en_o)
    else $error("sleep entry left a flag or peripheral clock on");
  a_secondary_run_mode_denied: assert property ( // R03
    ce_i && cs_q.st == ST_RUN && !sleep_req_i && !wdt_timeout_i &&
    cs_q.clock_select_field == SEL_SEC && !cs_q.secondary_osc_enable_bit
    |=> cs_q.st == ST_RUN && $stable(cs_q.src))
    else $error("secondary run entered with oscillator disabled");
  a_idle_cpu_off: assert property ( // R13
    ce_i && cs_q.st == ST_IDLE |=> !cpu_clk_en_o && periph_clk_en_o &&
    primary_clock_active_flag_o == $past(cs_q.src == SRC_PRI))
    else $error("idle clocking wrong");
  a_secondary_idle_mode_refused: assert property ( // R19
    ce_i && cs_q.st == ST_RUN && sleep_req_i && !wdt_timeout_i && cs_q.idle_enable_bit &&
    cs_q.clock_select_field == SEL_SEC && !cs_q.secondary_osc_enable_bit
    |=> cs_q.st == ST_RUN)
    else $error("secondary idle entered with oscillator disabled");
  a_ready_delay_len: assert property ( // R14
    $fell(cs_q.st == ST_READY) |-> rdy_len_q == CNT_W'(READY_CYC) && cs_q.st == ST_RUN)
    else $error("cpu ready delay length wrong");
  a_wdt_wakes: assert property ( // R15
    ce_i && (cs_q.st == ST_IDLE || cs_q.st == ST_SLEEP) && wdt_timeout_i
    |=> cs_q.st != ST_IDLE && cs_q.st != ST_SLEEP && !wdt_reset_o)
    else $error("watchdog timeout did not wake");
  a_sec_hold_clocks: assert property ( // R04
    ce_i && hold |=> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clocks ran before secondary oscillated");
  a_select_kept: assert property ( // R09
    !(ce_i && psel_i && penable_i && cs_q.pready && pwrite_i && paddr_i == OSC_CTRL_ADDR)
    |=> $stable(cs_q.clock_select_field) && $stable(cs_q.idle_enable_bit))
    else $error("select or idle bit changed without a write");
  a_int_osc_kept: assert property ( // R08
    ce_i && (wdt_en_i || fscm_en_i) |=> internal_osc_en_o)
    else $error("internal oscillator stopped while needed");
  a_pri_flag_switch: assert property ( // R05
    ce_i && cs_q.st == ST_SWITCH && cnt.done && cs_q.sw_tgt == SRC_PRI && !sleep_req_i ##1 ce_i
    |=> primary_clock_active_flag_o && !secondary_clock_active_flag_o)
    else $error("primary flag not set after switch");
endmodule // pmc_top

// file: testbench/pmc_osc_model.sv
// oscillator sources facing the clock controller: enables in, ready levels out
// assumes the enables are registered on ref_clk_i
`timescale 1ns/1ps
module pmc_osc_model #(
  parameter int unsigned START_CYC = 30
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  // oscillator enables and status
  input  wire logic primary_osc_en_i,
  input  wire logic secondary_osc_en_i,
  output logic      primary_ready_o,
  output logic      secondary_running_o
);
  // ---------------------------------------------
  // start-up counters
  // ---------------------------------------------
  // slow start on purpose, so hold-off windows can be seen
  int unsigned pri_cnt;
  int unsigned sec_cnt;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pri_cnt <= 0;
      sec_cnt <= 0;
    end else begin
      pri_cnt <= primary_osc_en_i ? pri_cnt + (pri_cnt < START_CYC) : 0;
      sec_cnt <= secondary_osc_en_i ? sec_cnt + (sec_cnt < START_CYC) : 0;
    end
  end

  assign primary_ready_o     = (pri_cnt >= START_CYC);
  assign secondary_running_o = (sec_cnt >= START_CYC);
endmodule // pmc_osc_model

// file: testbench/testbench.sv
// self-checking bench for pmc_top: apb registers and run, idle, sleep sequencing
// assumes pmc_osc_model as oscillator partner and a 200 MHz clock
`timescale 1ns/1ps
module testbench;
  import pmc_pkg::*;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic        ref_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
  logic        pready_o, pslverr_o, err_seen, primary_ready_i, secondary_running_i;
  logic        sleep_req_i = 1'b0, wake_irq_i = 1'b0, wdt_timeout_i = 1'b0;
  logic        wdt_en_i = 1'b0, fscm_en_i = 1'b0, two_speed_en_i = 1'b0;
  logic        cpu_clk_en_o, periph_clk_en_o, primary_osc_en_o, secondary_osc_en_o;
  logic        internal_osc_en_o, wdt_reset_o;
  logic        primary_clock_active_flag_o, secondary_clock_active_flag_o;
  logic [1:0]  clk_src_o;
  int          num_errors = 0, num_checks = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  pmc_top #(.READY_CYC(3)) dut_u (.ref_clk_i, .reset_n_i, .ce_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sleep_req_i,
    .wake_irq_i, .wdt_timeout_i, .wdt_en_i, .fscm_en_i, .two_speed_en_i, .primary_ready_i,
    .secondary_running_i, .cpu_clk_en_o, .periph_clk_en_o, .clk_src_o, .primary_osc_en_o,
    .secondary_osc_en_o, .internal_osc_en_o, .primary_clock_active_flag_o,
    .secondary_clock_active_flag_o, .wdt_reset_o);

  pmc_osc_model #(.START_CYC(30)) osc_u (.ref_clk_i, .reset_n_i,
    .primary_osc_en_i(primary_osc_en_o), .secondary_osc_en_i(secondary_osc_en_o),
    .primary_ready_o(primary_ready_i), .secondary_running_o(secondary_running_i));

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic close_out();
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // setup edge, then hold until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 50);
    if (i >= 50) begin
      num_errors++;
      close_out();
    end
    rd = prdata_o;
    err_seen = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // which 0 waits on clk_src_o, 1 on cpu_clk_en_o
  task automatic wait_for(input int which, input logic [1:0] v);
    int i;
    for (i = 0; i < 300 && (which == 0 ? clk_src_o : {1'b0, cpu_clk_en_o}) !== v; i++)
      @(posedge ref_clk_i);
    if (i >= 300) begin
      num_errors++;
      close_out();
    end
    tick(2);
  endtask

  // v is {watchdog timeout, wake interrupt, sleep}
  task automatic pulse(input logic [2:0] v);
    @(posedge ref_clk_i);
    {wdt_timeout_i, wake_irq_i, sleep_req_i} <= v;
    @(posedge ref_clk_i);
    {wdt_timeout_i, wake_irq_i, sleep_req_i} <= 3'b000;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic sc_reset();
    tick(4);
    chk(clk_src_o, 2'h1);
    chk(primary_clock_active_flag_o, 1'b1);
    apb(1'b0, OSC_CTRL_ADDR, 32'h0000_0000);
    chk(rd & 32'h0000_008b, 32'h0000_000a);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(err_seen, 1'b1);
  endtask

  task automatic sc_secondary();
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0001);
    tick(20);
    chk(clk_src_o, 2'h1);
    apb(1'b1, TMR_CTRL_ADDR, 32'h0000_0008);
    tick(4);
    chk(periph_clk_en_o, 1'b0);
    wait_for(0, 2'h2);
    chk(secondary_clock_active_flag_o, 1'b1);
    chk(primary_clock_active_flag_o, 1'b0);
    chk(primary_osc_en_o, 1'b0);
    apb(1'b0, OSC_CTRL_ADDR, 32'h0000_0000);
    chk(rd[1:0], 2'h1);
    // primary needs its start-up, so secondary keeps clocking meanwhile
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0002);
    tick(3);
    chk(clk_src_o, 2'h2);
    wait_for(0, 2'h1);
    chk(secondary_clock_active_flag_o, 1'b0);
    chk(secondary_osc_en_o, 1'b1);
  endtask

  task automatic sc_internal_idle();
    wdt_en_i <= 1'b1;
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0003);
    wait_for(0, 2'h3);
    chk(primary_clock_active_flag_o | secondary_clock_active_flag_o, 1'b0);
    chk(primary_osc_en_o, 1'b0);
    chk(internal_osc_en_o, 1'b1);
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0083);
    pulse(3'b001);
    tick(20);
    chk({cpu_clk_en_o, periph_clk_en_o, clk_src_o}, 4'h7);
    pulse(3'b010);
    chk(cpu_clk_en_o, 1'b0);
    wait_for(1, 2'h1);
    chk(clk_src_o, 2'h3);
    apb(1'b0, OSC_CTRL_ADDR, 32'h0000_0000);
    chk(rd & 32'h0000_0083, 32'h0000_0083);
  endtask

  task automatic sc_sleep_primary_idle();
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0003);
    pulse(3'b001);
    tick(3);
    chk({primary_clock_active_flag_o, secondary_clock_active_flag_o}, 2'h0);
    chk({cpu_clk_en_o, periph_clk_en_o}, 2'h0);
    chk({secondary_osc_en_o, internal_osc_en_o}, 2'h3);
    pulse(3'b100);
    wait_for(1, 2'h1);
    chk(clk_src_o, 2'h3);
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0082);
    wait_for(0, 2'h1);
    pulse(3'b001);
    tick(3);
    chk({cpu_clk_en_o, primary_clock_active_flag_o, primary_osc_en_o}, 3'h3);
    pulse(3'b010);
    wait_for(1, 2'h1);
    chk({clk_src_o, primary_clock_active_flag_o}, 3'h3);
  endtask

  task automatic sc_secondary_idle_mode_refused();
    apb(1'b1, TMR_CTRL_ADDR, 32'h0000_0000);
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0081);
    pulse(3'b001);
    tick(4);
    chk({cpu_clk_en_o, clk_src_o}, 3'h5);
    pulse(3'b100);
    tick(1);
    chk({wdt_reset_o, cpu_clk_en_o}, 2'h3);
    // select then sleep at once: the sleep lands mid-switch
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0080);
    pulse(3'b001);
    tick(12);
    chk({cpu_clk_en_o, periph_clk_en_o, clk_src_o, primary_clock_active_flag_o}, 5'h0e);
    fscm_en_i <= 1'b1;
    pulse(3'b010);
    wait_for(1, 2'h1);
    apb(1'b1, OSC_CTRL_ADDR, 32'h0000_0002);
    pulse(3'b001);
    tick(3);
    chk({cpu_clk_en_o, periph_clk_en_o, primary_clock_active_flag_o}, 3'h0);
    pulse(3'b010);
    wait_for(1, 2'h1);
    chk(clk_src_o, 2'h3);
    wait_for(0, 2'h1);
    chk(primary_clock_active_flag_o, 1'b1);
  endtask

  initial begin
    tick(12);
    reset_n_i <= 1'b1;
    sc_reset();
    sc_secondary();
    sc_internal_idle();
    sc_sleep_primary_idle();
    sc_secondary_idle_mode_refused();
    close_out();
  end
endmodule // testbench
